// [rtl/gpio_evt_if.sv]
// sampled pin levels and event strobes between gpio core and irq unit
interface gpio_evt_if;
  logic [247:0] lvl;
  logic [7:0] pin_hit;
  logic [7:0] pin_sel_idx0;
  logic [1:0] grp_hit;
  modport src (output lvl, input pin_hit, input grp_hit);
  modport dst (input lvl, output pin_hit, output grp_hit);
endinterface

// [rtl/gpio_irq.sv]
// pin interrupt and group interrupt event detection
`include "gpio_params.svh"
module gpio_irq
(
  input wire logic clk,
  input wire logic rst,
  gpio_evt_if.dst evt,
  input wire logic [63:0] pin_sel,
  input wire logic [7:0] pin_level_mode,
  input wire logic [247:0] grp_en0,
  input wire logic [247:0] grp_en1
);
  import gpio_pkg::*;
  logic [7:0] cur;
  logic [7:0] prev_q;
  logic [1:0] gcur;
  logic [1:0] gprev_q;
  // each pin interrupt picks one pin out of all ports
  genvar i;
  for (i = 0; i < `GP_NPINT; i++)
  begin : g_pin
    assign cur[i] = evt.lvl[pin_sel[8*i +: 8]];
    // level mode fires while high, edge mode on a rise
    assign evt.pin_hit[i] = pin_level_mode[i] ? cur[i]
                                              : (cur[i] & ~prev_q[i]); // RQ12
  end
  // groups fire when the OR of their selected pins goes high
  assign gcur[0] = |(evt.lvl & grp_en0); // RQ13
  assign gcur[1] = |(evt.lvl & grp_en1); // RQ13
  assign evt.grp_hit = gcur & ~gprev_q;
  // history for edge detection
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prev_q <= 8'h00;
      gprev_q <= 2'h0;
    end
    else
    begin
      prev_q <= cur;
      gprev_q <= gcur;
    end
  end
endmodule // gpio_irq

// [rtl/gpio_lane_merge.sv]
// byte-lane merge of write data into a register word
module gpio_lane_merge
(
  input wire logic [30:0] old_val,
  input wire logic [31:0] wdata,
  input wire logic [3:0] strb,
  output logic [30:0] new_val
);
  logic [31:0] full;
  // old value widened to a full word so each lane can be sliced
  logic [31:0] old_ext;
  assign old_ext = {1'b0, old_val};
  // each lane takes write data only if its strobe is set
  genvar b;
  for (b = 0; b < 4; b++)
  begin : g_lane
    assign full[8*b +: 8] = strb[b] ? wdata[8*b +: 8]
                                    : old_ext[8*b +: 8];
  end
  assign new_val = full[30:0];
endmodule // gpio_lane_merge

// [rtl/gpio_params.svh]
// offsets, field positions, reset values and counts of the gpio block
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
`define GP_NPORT 8
`define GP_NPIN 31
`define GP_NPINT 8
`define GP_NGRP 2
// address bits [7:5] pick the port, [4:2] the register kind
`define GP_PORT_LSB 5
`define GP_KIND_LSB 2
`define GP_OFF_DIR 3'h0
`define GP_OFF_MASK 3'h1
`define GP_OFF_PIN 3'h2
`define GP_OFF_MPIN 3'h3
`define GP_OFF_SET 3'h4
`define GP_OFF_CLR 3'h5
`define GP_OFF_NOT 3'h6
`define GP_OFF_OUT 3'h7
// interrupt and group block base at 0x100
`define GP_OFF_IRQ_BASE 9'h100
`define GP_OFF_PSEL 9'h100
`define GP_OFF_PMODE 9'h104
`define GP_OFF_PSTAT 9'h108
`define GP_OFF_PMASK 9'h10C
`define GP_OFF_GSTAT 9'h110
`define GP_OFF_GMASK 9'h114
`define GP_OFF_GEN0 9'h120
`define GP_OFF_GEN1 9'h140
`define GP_RST_DIR 31'h00000000
`define GP_RST_OUT 31'h00000000
`define GP_RST_PU 31'h7FFFFFFF
`endif

// [rtl/gpio_pkg.sv]
// types shared by the gpio modules
package gpio_pkg;
  typedef logic [30:0] pins_t;
  typedef logic [7:0] sel_t;
  typedef enum logic [2:0]
  {
    BUS_IDLE = 3'b001,
    BUS_SETUP = 3'b010,
    BUS_ACCESS = 3'b100
  } bus_state_e;
endpackage

// [rtl/gpio_top.sv]
// gpio block top: apb slave, port registers, pins and interrupt status
//
// Local design decisions: the APB slave port and the address map.
`include "gpio_params.svh"
// Functional notes
// (RQ1) eight ports of thirty-one pins each
// (RQ2) free pins driven and sensed by registers
// (RQ3) per-pin direction, changeable any time
// (RQ4) set and clear registers, zeros ignored
// (RQ5) read output register and live pins
// (RQ6) reset: inputs, pull-up on, buffer off
// (RQ7) software enables input buffer before reading
// (RQ8) mask registers select bits as group
// (RQ9) byte and halfword accesses per lane
// (RQ10) whole port written in one access
// (RQ11) direct bus slave, minimal latency
// (RQ12) eight selectable pin irqs, edge or level
// (RQ13) two group interrupts from chosen pins
// (RQ14) later bus write wins set versus clear
module gpio_top
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [247:0] pin_in,
  input wire logic [247:0] periph_owned,
  input wire logic [247:0] periph_out,
  input wire logic [247:0] periph_oe,
  input wire logic [247:0] in_buf_en,
  output logic [247:0] pin_out,
  output logic [247:0] pin_oe,
  output logic [247:0] pull_up_en,
  output logic irq
);
  import gpio_pkg::*;

  gpio_evt_if evt ();
  // per-port register storage
  pins_t dir_q [`GP_NPORT]; // 1 = output
  pins_t out_q [`GP_NPORT]; // output register
  pins_t mask_q [`GP_NPORT]; // 1 = bit excluded
  logic [63:0] pin_sel_q; // eight 8-bit pin indexes
  logic [7:0] pmode_q; // 1 = level sensitive
  logic [7:0] pstat_q; // sticky pin events
  logic [7:0] pmask_q; // pin irq enables
  logic [1:0] gstat_q; // sticky group events
  logic [1:0] gmask_q; // group irq enables
  logic [247:0] gen0_q; // group 0 pin enables
  logic [247:0] gen1_q; // group 1 pin enables
  logic [247:0] lvl; // gated live pin levels
  logic [31:0] rdata_d;
  logic [31:0] prdata_q;
  logic wr;
  logic rd;
  logic is_port;
  logic [2:0] port;
  logic [2:0] kind;
  logic [2:0] gsub;
  logic [8:0] off;
  logic hit;
  logic [31:0] pstat_clr;
  logic [31:0] gstat_clr;

  // access decode: one-cycle access phase, no wait states
  assign wr = psel & penable & pwrite; // RQ11
  assign rd = psel & penable & ~pwrite;
  assign off = paddr[8:0];
  assign is_port = (paddr[11:8] == 4'h0);
  assign port = paddr[`GP_PORT_LSB +: 3];
  assign kind = paddr[`GP_KIND_LSB +: 3];
  assign gsub = paddr[4:2];
  assign pready = 1'b1; // RQ11
  assign pslverr = 1'b0;

  // live levels are valid only with the input buffer on
  assign lvl = pin_in & in_buf_en; // RQ7
  assign evt.lvl = lvl;
  assign evt.pin_sel_idx0 = pin_sel_q[7:0];

  // pin muxing: peripheral pins bypass the port registers
  genvar p;
  for (p = 0; p < `GP_NPORT; p++)
  begin : g_pins
    logic [30:0] pin_new;
    logic [30:0] mdat_new;
    logic [30:0] dir_new;
    logic [30:0] msk_new;
    logic sel_me;
    assign sel_me = wr & is_port & (port == 3'(p));
    assign pin_out[31*p +: 31] = periph_owned[31*p +: 31] & periph_out[31*p +: 31]
      | ~periph_owned[31*p +: 31] & out_q[p]; // RQ2
    assign pin_oe[31*p +: 31] = periph_owned[31*p +: 31] & periph_oe[31*p +: 31]
      | ~periph_owned[31*p +: 31] & dir_q[p]; // RQ2
    // pull-ups stay on for every input pin
    assign pull_up_en[31*p +: 31] = ~pin_oe[31*p +: 31]; // RQ6

    // lane merges for plain, masked, direction and mask writes
    gpio_lane_merge u_pin
    (
      .old_val(out_q[p]),
      .wdata(pwdata),
      .strb(pstrb),
      .new_val(pin_new)
    );
    gpio_lane_merge u_mpin
    (
      .old_val(out_q[p]),
      .wdata(pwdata),
      .strb(pstrb),
      .new_val(mdat_new)
    );
    gpio_lane_merge u_dir
    (
      .old_val(dir_q[p]),
      .wdata(pwdata),
      .strb(pstrb),
      .new_val(dir_new)
    );
    gpio_lane_merge u_msk
    (
      .old_val(mask_q[p]),
      .wdata(pwdata),
      .strb(pstrb),
      .new_val(msk_new)
    );

    // direction register, writable any time
    always_ff @(posedge clk)
    begin
      if (rst)
        dir_q[p] <= `GP_RST_DIR; // RQ6
      else if (sel_me && kind == `GP_OFF_DIR)
        dir_q[p] <= dir_new; // RQ3 RQ9
    end

    // mask register
    always_ff @(posedge clk)
    begin
      if (rst)
        mask_q[p] <= 31'h00000000;
      else if (sel_me && kind == `GP_OFF_MASK)
        mask_q[p] <= msk_new; // RQ9
    end

    // output register: one bus access at a time, so the later wins
    always_ff @(posedge clk)
    begin
      if (rst)
        out_q[p] <= `GP_RST_OUT;
      else if (sel_me)
      begin
        case (kind)
          `GP_OFF_PIN, `GP_OFF_OUT:
            out_q[p] <= pin_new; // RQ10 RQ9
          `GP_OFF_MPIN:
            out_q[p] <= (out_q[p] & mask_q[p])
              | (mdat_new & ~mask_q[p]); // RQ8
          `GP_OFF_SET:
            out_q[p] <= out_q[p] | (pwdata[30:0]
              & {{7{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                 {8{pstrb[0]}}}); // RQ4 RQ14
          `GP_OFF_CLR:
            out_q[p] <= out_q[p] & ~(pwdata[30:0]
              & {{7{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                 {8{pstrb[0]}}}); // RQ4 RQ14
          `GP_OFF_NOT:
            out_q[p] <= out_q[p] ^ (pwdata[30:0]
              & {{7{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}},
                 {8{pstrb[0]}}});
          default:
            out_q[p] <= out_q[p];
        endcase
      end
    end
  end

  // pin and group event detection
  gpio_irq u_irq
  (
    .clk(clk),
    .rst(rst),
    .evt(evt),
    .pin_sel(pin_sel_q),
    .pin_level_mode(pmode_q),
    .grp_en0(gen0_q),
    .grp_en1(gen1_q)
  );

  // interrupt configuration registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_sel_q <= 64'h0;
      pmode_q <= 8'h00;
      pmask_q <= 8'h00;
      gmask_q <= 2'h0;
    end
    else if (wr && !is_port)
    begin
      case (off)
        `GP_OFF_PSEL:
          pin_sel_q[31:0] <= pwdata; // RQ12
        `GP_OFF_PSEL + 9'h010:
          pin_sel_q[63:32] <= pwdata; // RQ12
        `GP_OFF_PMODE:
          pmode_q <= pwdata[7:0]; // RQ12
        `GP_OFF_PMASK:
          pmask_q <= pwdata[7:0];
        `GP_OFF_GMASK:
          gmask_q <= pwdata[1:0];
        default:
          pmode_q <= pmode_q;
      endcase
    end
  end

  // group enables, one word per port in each group bank
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      gen0_q <= 248'h0;
      gen1_q <= 248'h0;
    end
    else if (wr && !is_port && off[8:5] == `GP_OFF_GEN0 >> 5)
      gen0_q[31*gsub +: 31] <= pwdata[30:0]; // RQ13
    else if (wr && !is_port && off[8:5] == `GP_OFF_GEN1 >> 5)
      gen1_q[31*gsub +: 31] <= pwdata[30:0]; // RQ13
  end

  // write-one-to-clear strobes
  assign pstat_clr = (wr && !is_port && off == `GP_OFF_PSTAT) ? pwdata
                                                              : 32'h0;
  assign gstat_clr = (wr && !is_port && off == `GP_OFF_GSTAT) ? pwdata
                                                              : 32'h0;

  // sticky status: a new event beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pstat_q <= 8'h00;
      gstat_q <= 2'h0;
    end
    else
    begin
      pstat_q <= (pstat_q & ~pstat_clr[7:0]) | evt.pin_hit; // RQ12
      gstat_q <= (gstat_q & ~gstat_clr[1:0]) | evt.grp_hit; // RQ13
    end
  end

  // level interrupt while an unmasked status bit is set
  always_ff @(posedge clk)
  begin
    if (rst)
      irq <= 1'b0;
    else
      irq <= |(pstat_q & pmask_q) | |(gstat_q & gmask_q);
  end

  // read mux
  always_comb
  begin
    rdata_d = 32'h0;
    hit = 1'b1;
    if (is_port)
    begin
      case (kind)
        `GP_OFF_DIR: rdata_d = {1'b0, dir_q[port]};
        `GP_OFF_MASK: rdata_d = {1'b0, mask_q[port]};
        `GP_OFF_PIN: rdata_d = {1'b0, lvl[31*port +: 31]}; // RQ5
        `GP_OFF_MPIN: rdata_d = {1'b0, lvl[31*port +: 31]
                                       & ~mask_q[port]}; // RQ8
        `GP_OFF_OUT, `GP_OFF_SET: rdata_d = {1'b0, out_q[port]}; // RQ5
        default: rdata_d = 32'h0;
      endcase
    end
    else
    begin
      case (off)
        `GP_OFF_PSEL: rdata_d = pin_sel_q[31:0];
        `GP_OFF_PSEL + 9'h010: rdata_d = pin_sel_q[63:32];
        `GP_OFF_PMODE: rdata_d = {24'h0, pmode_q};
        `GP_OFF_PSTAT: rdata_d = {24'h0, pstat_q};
        `GP_OFF_PMASK: rdata_d = {24'h0, pmask_q};
        `GP_OFF_GSTAT: rdata_d = {30'h0, gstat_q};
        `GP_OFF_GMASK: rdata_d = {30'h0, gmask_q};
        default: hit = 1'b0;
      endcase
    end
  end

  // read data captured in the setup cycle, valid in the access cycle
  always_ff @(posedge clk)
  begin
    if (rst)
      prdata_q <= 32'h0;
    else if (psel && !penable && !pwrite)
      prdata_q <= hit ? rdata_d : 32'h0;
  end
  assign prdata = rd ? prdata_q : 32'h0;
endmodule // gpio_top

// [tb/general_purpose_io_ports_tb.sv]
// self-checking bench of the gpio block
module general_purpose_io_ports_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd_v;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, irq;
  logic [247:0] pin_in, periph_owned = '0, periph_out = '0, periph_oe = '0;
  logic [247:0] in_buf_en = '0, pin_out, pin_oe, pull_up_en;
  logic [247:0] ext_val = '0, ext_drv = '0;
  int n_errors = 0, comparisons = 0;
  // 250 MHz clock
  always #2 clk = ~clk;
  gpio_top u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .pin_in, .periph_owned, .periph_out,
    .periph_oe, .in_buf_en, .pin_out, .pin_oe, .pull_up_en, .irq);
  pin_model u_pins (.pin_out, .pin_oe, .pull_up_en, .ext_val, .ext_drv,
    .pin_level(pin_in));
  // compare one value, count it
  task automatic chk(string nm, logic [247:0] exp, logic [247:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, exp, got);
    end
  endtask
  // apb transfer: setup, access held until pready
  task automatic xfer(logic w, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd_v = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d, logic [3:0] s = 4'hF);
    xfer(1'b1, a, d, s);
  endtask
  task automatic rd(logic [11:0] a);
    xfer(1'b0, a, '0, 4'h0);
  endtask
  // summary and verdict
  task automatic end_sim;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // reset state, buffer off, unmapped read
  task automatic t_reset;
    rd(12'h000);
    chk("dir", '0, rd_v);
    chk("oe", '0, pin_oe);
    chk("pull", {248{1'b1}}, pull_up_en);
    rd(12'h008);
    chk("pins buffer off", '0, rd_v);
    rd(12'h200);
    chk("unmapped", '0, rd_v);
    $display("t_reset done");
  endtask
  // direction, set, clear, lanes, whole port
  task automatic t_out;
    wr(12'h000, 32'h0000FFFF);
    wr(12'h010, 32'h00000F0F);
    wr(12'h014, 32'h00000303);
    rd(12'h01C);
    chk("out", 32'h00000C0C, rd_v);
    chk("oe", 31'h0000FFFF, pin_oe[30:0]);
    @(posedge clk);
    in_buf_en <= {248{1'b1}};
    rd(12'h008);
    chk("pins", 32'h7FFF0C0C, rd_v);
    wr(12'h01C, 32'hAABBCCDD, 4'b0010);
    rd(12'h01C);
    chk("lane", 32'h0000CC0C, rd_v);
    wr(12'h05C, 32'h7FFFFFFF);
    rd(12'h05C);
    chk("port2", 32'h7FFFFFFF, rd_v);
    wr(12'h010, 32'h40000000);
    wr(12'h014, 32'h40000000);
    rd(12'h01C);
    chk("set then clear", 32'h0000CC0C, rd_v);
    $display("t_out done");
  endtask
  // masked write and masked read
  task automatic t_mask;
    wr(12'h004, 32'h000000F0);
    wr(12'h00C, 32'hFFFFFFFF);
    rd(12'h01C);
    chk("masked write", 32'h7FFFFF0F, rd_v);
    rd(12'h00C);
    chk("masked read", 32'h7FFFFF0F, rd_v);
    $display("t_mask done");
  endtask
  // peripheral-owned pin passes through
  task automatic t_periph;
    @(posedge clk);
    periph_owned[31] <= 1'b1;
    periph_oe[31] <= 1'b1;
    periph_out[31] <= 1'b1;
    @(posedge clk);
    chk("periph oe", 1'b1, pin_oe[31]);
    chk("periph out", 1'b1, pin_out[31]);
    periph_owned[31] <= 1'b0;
    @(posedge clk);
    chk("gpio oe", 1'b0, pin_oe[31]);
    $display("t_periph done");
  endtask
  // pin irq on port0 pin 20: edge, mask, clear, level
  task automatic t_irq;
    @(posedge clk);
    ext_drv[20] <= 1'b1;
    wr(12'h100, 32'h00000014);
    wr(12'h104, 32'h0);
    wr(12'h10C, 32'h00000001);
    wr(12'h108, 32'h000000FF);
    repeat (2) @(posedge clk);
    chk("irq idle", 1'b0, irq);
    ext_drv[20] <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq edge", 1'b1, irq);
    wr(12'h10C, 32'h00000000);
    repeat (2) @(posedge clk);
    chk("irq masked", 1'b0, irq);
    rd(12'h108);
    chk("status", 32'h1, rd_v);
    wr(12'h104, 32'h1);
    wr(12'h108, 32'h1);
    rd(12'h108);
    chk("level status", 32'h1, rd_v);
    wr(12'h104, 32'h0);
    wr(12'h108, 32'h1);
    rd(12'h108);
    chk("edge status", 32'h0, rd_v);
    $display("t_irq done");
  endtask
  // group 0 on port0 pin 21: rise of the pin raises irq
  task automatic t_grp;
    @(posedge clk);
    ext_drv[21] <= 1'b1;
    wr(12'h120, 32'h00200000);
    wr(12'h114, 32'h00000001);
    wr(12'h110, 32'h00000003);
    repeat (2) @(posedge clk);
    chk("grp idle", 1'b0, irq);
    ext_drv[21] <= 1'b0;
    repeat (3) @(posedge clk);
    chk("grp edge", 1'b1, irq);
    $display("t_grp done");
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_out;
    t_mask;
    t_periph;
    t_irq;
    t_grp;
    end_sim;
  end
  // watchdog
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    end_sim;
  end
endmodule // general_purpose_io_ports_tb

// [tb/gpio_top_asserts.sv]
// port-level checks of the gpio top
module gpio_top_asserts
(
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [247:0] periph_owned,
  input wire logic [247:0] periph_oe,
  input wire logic [247:0] pin_out,
  input wire logic [247:0] pin_oe,
  input wire logic [247:0] pull_up_en,
  input wire logic irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // full-word write in its access cycle
  wire wr = psel && penable && pwrite && pstrb == 4'hF;
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_no_error: assert property (!pslverr)
    else $error("pslverr high");
  a_reset_state: assert property ($past(rst) |-> pin_oe == '0 && !irq)
    else $error("pins or irq not idle after reset");
  a_pull_up: assert property (pull_up_en == ~pin_oe)
    else $error("pull-up not on undriven pins");
  a_periph_pass: assert property ((periph_owned & pin_oe) == (periph_owned & periph_oe))
    else $error("peripheral enable not passed");
  a_rdata_idle: assert property (!(psel && penable && !pwrite) |-> prdata == '0)
    else $error("read data outside read access");
  a_dir_write: assert property (wr && paddr == 12'h000 |=> pin_oe[30:0] == $past(pwdata[30:0]))
    else $error("direction write not applied");
  a_set_bits: assert property (wr && paddr == 12'h010 |=> pin_out[30:0] == ($past(pin_out[30:0]) | $past(pwdata[30:0])))
    else $error("set write wrong");
  a_clr_bits: assert property (wr && paddr == 12'h014 |=> pin_out[30:0] == ($past(pin_out[30:0]) & ~$past(pwdata[30:0])))
    else $error("clear write wrong");
  a_out_word: assert property (wr && paddr == 12'h01C |=> pin_out[30:0] == $past(pwdata[30:0]))
    else $error("whole port write wrong");
endmodule // gpio_top_asserts
bind gpio_top gpio_top_asserts u_chk (.clk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .periph_owned,
  .periph_oe, .pin_out, .pin_oe, .pull_up_en, .irq);

// [tb/pin_model.sv]
// pad model: block drive, outside source and pull-up resolve each pin
module pin_model
(
  input wire logic [247:0] pin_out,
  input wire logic [247:0] pin_oe,
  input wire logic [247:0] pull_up_en,
  input wire logic [247:0] ext_val,
  input wire logic [247:0] ext_drv,
  output logic [247:0] pin_level
);
  // block drive wins, then the outside source, then the pull-up
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_drv & ext_val)
    | (~pin_oe & ~ext_drv & pull_up_en);
endmodule // pin_model
